// >>> hdl/i2c_clk_pkg.sv
// Constants for the two-wire controller clocking and interrupt-source block.
// Assumes a 16-bit I/O register port and a 250 MHz input clock.
`default_nettype none
package i2c_clk_pkg;
  // Register indices on the I/O port
  localparam logic [3:0] REG_INTERRUPT_SOURCE_CODE = 4'h0;
  localparam logic [3:0] REG_CLOCK_PRESCALER = 4'h1;
  localparam logic [3:0] REG_SCL_LOW_TIME_DIVIDER = 4'h2;
  localparam logic [3:0] REG_SCL_HIGH_TIME_DIVIDER = 4'h3;
  // Field positions
  localparam int EVENT_CODE_LSB = 0;
  localparam int EVENT_CODE_MSB = 2;
  localparam int TEST_MODE_LSB = 8;
  localparam int TEST_MODE_MSB = 11;
  localparam int PRESCALE_LSB = 0;
  localparam int PRESCALE_MSB = 7;
  // Reset values
  localparam logic [15:0] INTERRUPT_SOURCE_RESET = 16'h0000;
  localparam logic [15:0] CLOCK_PRESCALER_RESET = 16'h0000;
  localparam logic [15:0] SCL_LOW_RESET = 16'h0000;
  localparam logic [15:0] SCL_HIGH_RESET = 16'h0000;
  // Event codes
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_ARB_LOST = 3'h1;
  localparam logic [2:0] CODE_NACK = 3'h2;
  localparam logic [2:0] CODE_REGS_READY = 3'h3;
  localparam logic [2:0] CODE_RX_READY = 3'h4;
  localparam logic [2:0] CODE_TX_READY = 3'h5;
  // Phase offset added to each clock divisor
  localparam logic [2:0] OFFSET_PSC_ZERO = 3'h7;
  localparam logic [2:0] OFFSET_PSC_ONE = 3'h6;
  localparam logic [2:0] OFFSET_PSC_MORE = 3'h5;
  // Level driven on the open-drain clock pin while enabled
  localparam logic SCL_DRIVE_LEVEL = 1'h0;
endpackage
`default_nettype wire

// >>> hdl/i2c_intsrc_prescale_clockdiv.sv
// Interrupt source code, bus-busy tracking, prescaler and master clock shaping.
// Assumes synchronous bus pin samples and a 16-bit I/O register port with registered read data.
//
// How it works
// - No START/STOP detection while run bit low.
// - Event code sits in bits 2..0.
// - Codes: none, arb, nack, ready, rx, tx.
// - Reserved bits read zero, writes ignored.
// - Module clock is input clock over divisor+1.
// - Divisor loads only on run bit rising.
// - Master clock divides module clock, low/high divisors.
// - Low phase lasts low divisor plus offset.
// - Offset 7, 6 or 5 by divisor.
// - High phase lasts high divisor plus offset.
// - Reading arb/nack code clears that flag.
`default_nettype none
module i2c_intsrc_prescale_clockdiv #(
  parameter int DIV_WIDTH = 16,
  parameter int PSC_WIDTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [3:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  input wire logic module_run_enable,
  input wire logic master_active,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic arb_lost_set,
  input wire logic nack_set,
  input wire logic arb_lost_clear,
  input wire logic nack_clear,
  input wire logic regs_ready,
  input wire logic rx_ready,
  input wire logic tx_ready,
  output logic arb_lost_flag,
  output logic nack_flag,
  output logic bus_busy_flag,
  output logic [2:0] event_code,
  output logic [3:0] test_mode_field,
  output logic module_clk_tick,
  output logic scl_out,
  output logic scl_oe_n
);
  typedef enum logic [1:0] {SCL_IDLE, SCL_LOW, SCL_HIGH} scl_state_type;

  // Register-side state
  logic [PSC_WIDTH-1:0] prescale_divisor, next_prescale_divisor; // Software copy
  logic [PSC_WIDTH-1:0] active_prescale, next_active_prescale; // Copy in use
  logic [DIV_WIDTH-1:0] scl_low_divisor, next_scl_low_divisor;
  logic [DIV_WIDTH-1:0] scl_high_divisor, next_scl_high_divisor;
  logic [3:0] next_test_mode_field;
  logic [15:0] next_io_rdata;
  logic next_arb_lost_flag, next_nack_flag;
  logic [2:0] next_event_code;
  // Bus watching state
  logic run_prev, next_run_prev; // Detects the run bit rising
  logic scl_prev, sda_prev; // Previous pin samples
  logic next_bus_busy_flag;
  logic start_seen, stop_seen;
  // Master clock state
  scl_state_type scl_state, next_scl_state;
  logic [DIV_WIDTH:0] phase_count, next_phase_count; // Module clocks in phase
  logic next_scl_oe_n;
  logic [2:0] phase_offset;
  logic [DIV_WIDTH:0] low_target, high_target;
  logic isrc_read;

  assign isrc_read = io_rd && (io_addr == i2c_clk_pkg::REG_INTERRUPT_SOURCE_CODE);

  // Register writes, prescale capture, readback and flags
  always_comb begin
    next_prescale_divisor = prescale_divisor;
    next_scl_low_divisor = scl_low_divisor;
    next_scl_high_divisor = scl_high_divisor;
    next_test_mode_field = test_mode_field;
    next_active_prescale = active_prescale;
    next_run_prev = module_run_enable;
    next_io_rdata = io_rdata;
    if (io_wr) begin
      case (io_addr)
        // Only the test field is writable here; event code is read only
        i2c_clk_pkg::REG_INTERRUPT_SOURCE_CODE: begin
          next_test_mode_field = io_wdata[i2c_clk_pkg::TEST_MODE_MSB:i2c_clk_pkg::TEST_MODE_LSB];
        end
        i2c_clk_pkg::REG_CLOCK_PRESCALER: begin
          next_prescale_divisor = PSC_WIDTH'(io_wdata[i2c_clk_pkg::PRESCALE_MSB:i2c_clk_pkg::PRESCALE_LSB]);
        end
        i2c_clk_pkg::REG_SCL_LOW_TIME_DIVIDER: begin
          next_scl_low_divisor = DIV_WIDTH'(io_wdata);
        end
        i2c_clk_pkg::REG_SCL_HIGH_TIME_DIVIDER: begin
          next_scl_high_divisor = DIV_WIDTH'(io_wdata);
        end
        default: begin
          next_scl_low_divisor = scl_low_divisor;
        end
      endcase
    end
    // Divisor goes live only when the module leaves reset
    if (module_run_enable && !run_prev) begin
      next_active_prescale = prescale_divisor;
    end
    if (io_rd) begin
      next_io_rdata = 16'h0000;
      case (io_addr)
        i2c_clk_pkg::REG_INTERRUPT_SOURCE_CODE: begin
          next_io_rdata[i2c_clk_pkg::EVENT_CODE_MSB:i2c_clk_pkg::EVENT_CODE_LSB] = event_code;
          next_io_rdata[i2c_clk_pkg::TEST_MODE_MSB:i2c_clk_pkg::TEST_MODE_LSB] = test_mode_field;
        end
        i2c_clk_pkg::REG_CLOCK_PRESCALER: begin
          next_io_rdata[i2c_clk_pkg::PRESCALE_MSB:i2c_clk_pkg::PRESCALE_LSB] = 8'(prescale_divisor);
        end
        i2c_clk_pkg::REG_SCL_LOW_TIME_DIVIDER: begin
          next_io_rdata = 16'(scl_low_divisor);
        end
        i2c_clk_pkg::REG_SCL_HIGH_TIME_DIVIDER: begin
          next_io_rdata = 16'(scl_high_divisor);
        end
        default: begin
          next_io_rdata = 16'h0000;
        end
      endcase
    end
    // Flags: set wins over the clear strobes and the source read; module reset clears them even over a set
    next_arb_lost_flag = arb_lost_set ||
      (arb_lost_flag && !arb_lost_clear && !(isrc_read && event_code == i2c_clk_pkg::CODE_ARB_LOST));
    next_nack_flag = nack_set ||
      (nack_flag && !nack_clear && !(isrc_read && event_code == i2c_clk_pkg::CODE_NACK));
    if (!module_run_enable) begin
      next_arb_lost_flag = 1'b0;
      next_nack_flag = 1'b0;
    end
    // Highest-priority pending event gives the code
    if (next_arb_lost_flag) begin
      next_event_code = i2c_clk_pkg::CODE_ARB_LOST;
    end else if (next_nack_flag) begin
      next_event_code = i2c_clk_pkg::CODE_NACK;
    end else if (regs_ready) begin
      next_event_code = i2c_clk_pkg::CODE_REGS_READY;
    end else if (rx_ready) begin
      next_event_code = i2c_clk_pkg::CODE_RX_READY;
    end else if (tx_ready) begin
      next_event_code = i2c_clk_pkg::CODE_TX_READY;
    end else begin
      next_event_code = i2c_clk_pkg::CODE_NONE;
    end
  end

  // START is SDA falling with SCL high; STOP is SDA rising with SCL high
  assign start_seen = module_run_enable && scl_prev && scl_in && sda_prev && !sda_in;
  assign stop_seen = module_run_enable && scl_prev && scl_in && !sda_prev && sda_in;

  // Busy flag follows bus conditions, holds while in module reset
  always_comb begin
    if (start_seen) begin
      next_bus_busy_flag = 1'b1;
    end else if (stop_seen) begin
      next_bus_busy_flag = 1'b0;
    end else begin
      next_bus_busy_flag = bus_busy_flag;
    end
  end

  // Offset depends on the prescale divisor in use
  always_comb begin
    if (active_prescale == '0) begin
      phase_offset = i2c_clk_pkg::OFFSET_PSC_ZERO;
    end else if (active_prescale == PSC_WIDTH'(1)) begin
      phase_offset = i2c_clk_pkg::OFFSET_PSC_ONE;
    end else begin
      phase_offset = i2c_clk_pkg::OFFSET_PSC_MORE;
    end
  end

  assign low_target = {1'b0, scl_low_divisor} + {{(DIV_WIDTH-2){1'b0}}, phase_offset};
  assign high_target = {1'b0, scl_high_divisor} + {{(DIV_WIDTH-2){1'b0}}, phase_offset};

  // Master clock shaping in module clock ticks
  always_comb begin
    next_scl_state = scl_state;
    next_phase_count = phase_count;
    next_scl_oe_n = 1'b1;
    if (!module_run_enable || !master_active) begin
      next_scl_state = SCL_IDLE;
      next_phase_count = '0;
    end else begin
      case (scl_state)
        SCL_IDLE: begin
          next_scl_state = SCL_LOW;
          next_phase_count = '0;
          next_scl_oe_n = 1'b0;
        end
        SCL_LOW: begin
          next_scl_oe_n = 1'b0;
          if (module_clk_tick) begin
            if (phase_count + 1'b1 >= low_target) begin
              next_scl_state = SCL_HIGH;
              next_phase_count = '0;
              next_scl_oe_n = 1'b1;
            end else begin
              next_phase_count = phase_count + 1'b1;
            end
          end
        end
        SCL_HIGH: begin
          // High time counts only once the pin is really high
          if (module_clk_tick && scl_in) begin
            if (phase_count + 1'b1 >= high_target) begin
              next_scl_state = SCL_LOW;
              next_phase_count = '0;
              next_scl_oe_n = 1'b0;
            end else begin
              next_phase_count = phase_count + 1'b1;
            end
          end
        end
        default: begin
          next_scl_state = SCL_IDLE;
        end
      endcase
    end
  end

  // Module clock tick generator
  i2c_module_clock_divider #(
    .DIV_WIDTH(PSC_WIDTH)
  ) u_prescaler (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .run(module_run_enable),
    .divisor(active_prescale),
    .tick(module_clk_tick)
  );

  assign scl_out = i2c_clk_pkg::SCL_DRIVE_LEVEL;

  // All state registers, frozen while the clock enable is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prescale_divisor <= i2c_clk_pkg::CLOCK_PRESCALER_RESET[PSC_WIDTH-1:0];
      active_prescale <= i2c_clk_pkg::CLOCK_PRESCALER_RESET[PSC_WIDTH-1:0];
      scl_low_divisor <= i2c_clk_pkg::SCL_LOW_RESET;
      scl_high_divisor <= i2c_clk_pkg::SCL_HIGH_RESET;
      test_mode_field <= i2c_clk_pkg::INTERRUPT_SOURCE_RESET[11:8];
      event_code <= i2c_clk_pkg::CODE_NONE;
      io_rdata <= 16'h0000;
      arb_lost_flag <= 1'b0;
      nack_flag <= 1'b0;
      run_prev <= 1'b0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      bus_busy_flag <= 1'b0;
      scl_state <= SCL_IDLE;
      phase_count <= '0;
      scl_oe_n <= 1'b1;
    end else if (ce) begin
      prescale_divisor <= next_prescale_divisor;
      active_prescale <= next_active_prescale;
      scl_low_divisor <= next_scl_low_divisor;
      scl_high_divisor <= next_scl_high_divisor;
      test_mode_field <= next_test_mode_field;
      event_code <= next_event_code;
      io_rdata <= next_io_rdata;
      arb_lost_flag <= next_arb_lost_flag;
      nack_flag <= next_nack_flag;
      run_prev <= next_run_prev;
      scl_prev <= scl_in;
      sda_prev <= sda_in;
      bus_busy_flag <= next_bus_busy_flag;
      scl_state <= next_scl_state;
      phase_count <= next_phase_count;
      scl_oe_n <= next_scl_oe_n;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/i2c_module_clock_divider.sv
// Module clock prescaler: one tick every divisor+1 input clocks.
// Assumes the divisor is stable while run is high.
`default_nettype none
module i2c_module_clock_divider #(
  parameter int DIV_WIDTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic run,
  input wire logic [DIV_WIDTH-1:0] divisor,
  output logic tick
);
  logic [DIV_WIDTH-1:0] count; // Input clocks since last tick
  logic [DIV_WIDTH-1:0] next_count;

  // Wrap at the divisor, held cleared while the module is in reset
  always_comb begin
    if (!run || count == divisor) begin
      next_count = '0;
    end else begin
      next_count = count + 1'b1;
    end
  end

  // Tick marks the last input clock of each module clock period
  assign tick = run && (count == divisor);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= '0;
    end else if (ce) begin
      count <= next_count;
    end
  end
endmodule
`default_nettype wire

// >>> sim/i2c_bus_peer.sv
// Far-side bus model: another master that makes START and STOP.
// Assumes an open-drain bus with pull-ups on both lines.
`default_nettype none
module i2c_bus_peer (
  input wire logic clk,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  output logic scl_in,
  output logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pscl = 1'b1; // Peer clock drive, 1 = released
  logic psda = 1'b1; // Peer data drive, 1 = released
  // Wired-AND of both clock drivers; data has only this driver
  assign scl_in = (scl_oe_n ? 1'b1 : scl_out) & pscl;
  assign sda_in = psda;
  // Data falls while clock high, then clock pulled low
  task automatic start_cond();
    psda = 1'b1;
    pscl = 1'b1;
    repeat (2) @(negedge clk);
    psda = 1'b0;
    repeat (2) @(negedge clk);
    pscl = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // Clock low first so data can fall cleanly, then data rises under a high clock
  task automatic stop_cond();
    pscl = 1'b0;
    @(negedge clk);
    psda = 1'b0;
    @(negedge clk);
    pscl = 1'b1;
    repeat (2) @(negedge clk);
    psda = 1'b1;
    repeat (2) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// >>> sim/i2c_intsrc_prescale_clockdiv_assertions.sv
// Port checks for the clocking and interrupt-source block.
// Assumes one clock domain and the register map of i2c_clk_pkg.
`default_nettype none
module i2c_intsrc_prescale_clockdiv_assertions (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [3:0] io_addr,
  input wire logic io_rd,
  input wire logic [15:0] io_rdata,
  input wire logic module_run_enable,
  input wire logic master_active,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic arb_lost_set,
  input wire logic arb_lost_flag,
  input wire logic nack_flag,
  input wire logic bus_busy_flag,
  input wire logic [2:0] event_code,
  input wire logic scl_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !ce);
  // Data falls under a high clock, module running
  sequence start_seq;
    module_run_enable && $past(module_run_enable) && scl_in && $past(scl_in) && $past(sda_in) && !sda_in;
  endsequence
  // Data rises under a high clock, module running
  sequence stop_seq;
    module_run_enable && $past(module_run_enable) && scl_in && $past(scl_in) && !$past(sda_in) && sda_in;
  endsequence
  AST_BUSY_FROZEN: assert property (!module_run_enable |=> $stable(bus_busy_flag))
    else $error("busy flag moved in module reset");
  AST_BUSY_SET: assert property (start_seq |-> ##[1:2] bus_busy_flag)
    else $error("busy flag not set by start");
  AST_BUSY_CLEAR: assert property (stop_seq |-> ##[1:2] !bus_busy_flag)
    else $error("busy flag not cleared by stop");
  AST_CODE_ARB: assert property (arb_lost_flag |-> event_code == i2c_clk_pkg::CODE_ARB_LOST)
    else $error("arbitration code wrong");
  AST_CODE_NACK: assert property (!arb_lost_flag && nack_flag |-> event_code == i2c_clk_pkg::CODE_NACK)
    else $error("nack code wrong");
  AST_READ_CLEAR: assert property (io_rd && io_addr == i2c_clk_pkg::REG_INTERRUPT_SOURCE_CODE &&
    event_code == i2c_clk_pkg::CODE_ARB_LOST && !arb_lost_set |=> !arb_lost_flag)
    else $error("arbitration flag kept after source read");
  AST_ISRC_LAYOUT: assert property ($past(io_rd) && $past(io_addr) == 4'h0 |->
    io_rdata[15:12] == 4'h0 && io_rdata[7:3] == 5'h00 && io_rdata[2:0] == $past(event_code))
    else $error("source register readback wrong");
  AST_PSC_LAYOUT: assert property ($past(io_rd) && $past(io_addr) == 4'h1 |-> io_rdata[15:8] == 8'h00)
    else $error("prescaler upper byte not zero");
  AST_SCL_IDLE: assert property (!master_active [*2] |-> scl_oe_n)
    else $error("clock pin driven while not master");
endmodule
bind i2c_intsrc_prescale_clockdiv i2c_intsrc_prescale_clockdiv_assertions chk (.clk(clk), .sys_rst(sys_rst),
  .ce(ce), .io_addr(io_addr), .io_rd(io_rd), .io_rdata(io_rdata), .module_run_enable(module_run_enable),
  .master_active(master_active), .scl_in(scl_in), .sda_in(sda_in), .arb_lost_set(arb_lost_set),
  .arb_lost_flag(arb_lost_flag), .nack_flag(nack_flag), .bus_busy_flag(bus_busy_flag),
  .event_code(event_code), .scl_oe_n(scl_oe_n));
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the clocking and interrupt-source block.
// Assumes the peer model and checker are compiled alongside.
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] io_addr = 4'h0;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [15:0] io_wdata = 16'h0000;
  logic run = 1'b0; // Module run bit
  logic mact = 1'b0; // Master clock request
  logic [6:0] evt = 7'h00; // Arb set, nack set, arb clr, nack clr, regs, rx, tx
  logic [15:0] io_rdata;
  logic [2:0] code;
  logic [3:0] tmf;
  logic al_f, nk_f, busy, scl_in, sda_in, tick, scl_out, scl_oe_n;
  int error_cnt = 0;
  int samples_checked = 0;
  always #2 clk = ~clk;
  i2c_intsrc_prescale_clockdiv DUT (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .module_run_enable(run), .master_active(mact),
    .scl_in(scl_in), .sda_in(sda_in), .arb_lost_set(evt[6]), .nack_set(evt[5]), .arb_lost_clear(evt[4]),
    .nack_clear(evt[3]), .regs_ready(evt[2]), .rx_ready(evt[1]), .tx_ready(evt[0]), .arb_lost_flag(al_f),
    .nack_flag(nk_f), .bus_busy_flag(busy), .event_code(code), .test_mode_field(tmf), .module_clk_tick(tick),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n));
  i2c_bus_peer peer (.clk(clk), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .scl_in(scl_in), .sda_in(sda_in));
  // One register write, strobe held for one edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
    @(negedge clk);
  endtask
  // One register read compared with its expected word
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    `CHK("read data", e, io_rdata)
    @(negedge clk);
  endtask
  // One-cycle pulse on an event input
  task automatic pulse(input int b);
    evt[b] = 1'b1;
    @(negedge clk);
    evt[b] = 1'b0;
    @(negedge clk);
  endtask
  // Clocks from one module tick to the next
  task automatic gap_of(output int n);
    n = 0;
    while (tick !== 1'b1 && n < 600) begin @(negedge clk); n++; end
    n = 0;
    do begin @(negedge clk); n++; end while (tick !== 1'b1 && n < 600);
  endtask
  // Module ticks seen during one whole clock-pin phase
  task automatic phase(input logic lvl, output int n);
    int w = 0;
    while (scl_oe_n !== lvl && w < 3000) begin @(negedge clk); w++; end
    n = 0;
    while (scl_oe_n === lvl && w < 3000) begin n += int'(tick === 1'b1); @(negedge clk); w++; end
  endtask
  // Verdict and end of run
  task automatic end_sim();
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(negedge clk);
    error_cnt++;
    end_sim();
  end
  // Main test sequence
  initial begin
    int n;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 4; i++) rdc(4'(i), 16'h0000);
    wr(4'h0, 16'hF0FF);
    rdc(4'h0, 16'h0000);
    wr(4'h1, 16'hFFFF);
    rdc(4'h1, 16'h00FF);
    wr(4'h4, 16'hFFFF);
    rdc(4'h4, 16'h0000);
    wr(4'h2, 16'hA5C3);
    rdc(4'h2, 16'hA5C3);
    run = 1'b1;
    for (int i = 0; i < 3; i++) begin
      evt[i] = 1'b1;
      repeat (2) @(negedge clk);
      `CHK("level code", 3'(5 - i), code)
    end
    pulse(5);
    `CHK("nack code", i2c_clk_pkg::CODE_NACK, code)
    pulse(6);
    rdc(4'h0, 16'h0001);
    `CHK("arb flag", 1'b0, al_f)
    rdc(4'h0, 16'h0002);
    `CHK("nack flag", 1'b0, nk_f)
    pulse(6);
    pulse(4);
    `CHK("arb cleared", 1'b0, al_f)
    evt = 7'h00;
    run = 1'b0;
    peer.start_cond();
    `CHK("busy in reset", 1'b0, busy)
    peer.stop_cond();
    run = 1'b1;
    peer.start_cond();
    `CHK("busy after start", 1'b1, busy)
    run = 1'b0;
    peer.stop_cond();
    run = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("busy held", 1'b1, busy)
    peer.stop_cond();
    `CHK("busy after stop", 1'b0, busy)
    run = 1'b0;
    wr(4'h1, 16'h0002);
    run = 1'b1;
    gap_of(n);
    gap_of(n);
    `CHK("tick gap", 3, n)
    wr(4'h1, 16'h0000);
    gap_of(n);
    `CHK("gap unchanged", 3, n)
    wr(4'h2, 16'h0002);
    wr(4'h3, 16'h0003);
    for (int i = 0; i < 3; i++) begin
      run = 1'b0;
      wr(4'h1, 16'(i));
      run = 1'b1;
      repeat (4) @(negedge clk);
      `CHK("busy before transfer", 1'b0, busy)
      mact = 1'b1;
      phase(1'b0, n);
      `CHK("low ticks", 9 - i, n)
      phase(1'b1, n);
      `CHK("high ticks", 10 - i, n)
      mact = 1'b0;
      repeat (3) @(negedge clk);
      `CHK("clock released", 1'b1, scl_oe_n)
    end
    `CHK("clock level", 1'b0, scl_out)
    `CHK("test field", 4'h0, tmf)
    end_sim();
  end
endmodule
`default_nettype wire
